// *** verilog/urbd_defines.vh ***
// constants shared by the serial receiver with break and address detect
`ifndef URBD_DEFINES_VH
`define URBD_DEFINES_VH

// receive buffer shape: 9 data bits plus framing and parity error per entry
`define URBD_FIFO_DEPTH     4
`define URBD_FIFO_AW        2
`define URBD_FIFO_CW        3
`define URBD_FIFO_WIDTH     11
`define URBD_ENTRY_FRAME_ERR 9
`define URBD_ENTRY_PARITY_ERR 10

// oversampling: sixteen sub-ticks per bit, vote on ticks 7, 8 and 9
`define URBD_OVS_LAST       4'hf
`define URBD_SAMPLE_A       4'h7
`define URBD_SAMPLE_B       4'h8
`define URBD_SAMPLE_C       4'h9
`define URBD_BITS_EIGHT     4'h8
`define URBD_BITS_NINE      4'h9

// width and parity select codes
`define URBD_WPS_8N         2'h0
`define URBD_WPS_8E         2'h1
`define URBD_WPS_8O         2'h2
`define URBD_WPS_9N         2'h3

// receive interrupt select codes and fill thresholds
`define URBD_RXSEL_3UP      2'h2
`define URBD_RXSEL_FULL     2'h3
`define URBD_FILL_THREE     3'h3
`define URBD_FILL_FULL      3'h4

`endif

// *** verilog/urbd_rx_fifo.v ***
// four-entry receive buffer held in flip-flops, with flush
`timescale 1ns/1ps
`include "urbd_defines.vh"

module urbd_rx_fifo (
	input  wire                        clk,
	input  wire                        nrst,
	input  wire                        flush,
	input  wire                        push,
	input  wire [`URBD_FIFO_WIDTH-1:0] push_data,
	input  wire                        pop,
	output wire [`URBD_FIFO_WIDTH-1:0] head_data,
	output wire [`URBD_FIFO_CW-1:0]    count,
	output wire                        full
);

	reg  [`URBD_FIFO_WIDTH-1:0] mem_reg [0:`URBD_FIFO_DEPTH-1];
	reg  [`URBD_FIFO_AW-1:0]    wr_ptr_reg;
	reg  [`URBD_FIFO_AW-1:0]    rd_ptr_reg;
	reg  [`URBD_FIFO_CW-1:0]    count_reg;
	wire                        do_push;
	wire                        do_pop;

	assign full      = (count_reg == `URBD_FILL_FULL);
	assign count     = count_reg;
	assign head_data = mem_reg[rd_ptr_reg];
	// a push into a full buffer or a pop from an empty one is ignored
	assign do_push   = push & ~full & ~flush;
	assign do_pop    = pop & (count_reg != 3'h0) & ~flush;

	// =========================================================
	// storage
	genvar i;
	generate
		for (i = 0; i < `URBD_FIFO_DEPTH; i = i + 1) begin : g_entry
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					mem_reg[i] <= 11'h000;
				end else if (do_push && wr_ptr_reg == i) begin
					mem_reg[i] <= push_data;
				end
			end
		end
	endgenerate

	// =========================================================
	// pointers
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= 2'h0;
			rd_ptr_reg <= 2'h0;
			count_reg  <= 3'h0;
		end else if (flush) begin
			wr_ptr_reg <= 2'h0;
			rd_ptr_reg <= 2'h0;
			count_reg  <= 3'h0;
		end else begin
			if (do_push) begin
				wr_ptr_reg <= wr_ptr_reg + 2'h1;
			end
			if (do_pop) begin
				rd_ptr_reg <= rd_ptr_reg + 2'h1;
			end
			if (do_push && !do_pop) begin
				count_reg <= count_reg + 3'h1;
			end else if (do_pop && !do_push) begin
				count_reg <= count_reg - 3'h1;
			end
		end
	end

endmodule // urbd_rx_fifo

// *** verilog/urbd_receiver.v ***
// serial receiver with break-send override and 9-bit address detect
//
// Overview of operation
// - break bit forces transmit line low
// - break never raises transmit interrupt
// - recovery at 16x, shifter per bit
// - line level by three-sample majority vote
// - after stop bit, word enters buffer
// - buffer four entries of nine bits
// - fifth word sets overrun, held, blocked
// - clearing overrun flushes buffer, resumes
// - low stop bit sets framing error
// - parity error flags head word mismatch
// - error flags stored with each word
// - interrupt select chooses fill condition
// - select may change during reception
// - idle flag while shifter empty and no word held
// - data available while buffer not empty
// - address detect drops ninth-bit-clear words
// - address detect ignored in 8-bit mode
// - transmit line idles high when enabled
`timescale 1ns/1ps
`include "urbd_defines.vh"

module urbd_receiver (
	input  wire        clk,
	input  wire        nrst,
	input  wire        module_enable_bit,
	input  wire [1:0]  width_parity_select,
	input  wire        stop_bits_select,
	input  wire [15:0] baud_divisor_reg,
	input  wire [1:0]  rx_irq_select,
	input  wire        address_detect_enable,
	input  wire        break_send_bit,
	input  wire        tx_shift_busy,
	input  wire        tx_shift_bit,
	input  wire        tx_word_loaded,
	input  wire        serial_rx_line,
	input  wire        rx_read,
	input  wire        overrun_clear,
	input  wire        rx_irq_clear,
	output wire        serial_tx_line,
	output wire        tx_irq_set,
	output wire [8:0]  rx_data_register,
	output wire        framing_error_flag,
	output wire        parity_error_flag,
	output wire        rx_data_available,
	output wire        overrun_flag,
	output wire        receiver_idle_flag,
	output wire        rx_irq_flag
);

	localparam [4:0] ST_IDLE   = 5'h01;
	localparam [4:0] ST_START  = 5'h02;
	localparam [4:0] ST_DATA   = 5'h04;
	localparam [4:0] ST_PARITY = 5'h08;
	localparam [4:0] ST_STOP   = 5'h10;

	reg         tx_line_reg;
	reg         tx_irq_reg;
	reg         rx_meta_reg;
	reg         rx_sync_reg;
	reg  [15:0] div_reg;
	reg  [3:0]  sub_reg;
	reg         samp_a_reg;
	reg         samp_b_reg;
	reg  [4:0]  state_reg;
	reg  [3:0]  bits_reg;
	reg  [8:0]  shift_reg;
	reg         par_acc_reg;
	reg         parity_error_flag_reg;
	reg         framing_error_flag_reg;
	reg         stop2_reg;
	reg         armed_reg;
	reg  [8:0]  word_reg;
	reg         word_framing_error_flag_reg;
	reg         word_parity_error_flag_reg;
	reg         held_reg;
	reg         overrun_reg;
	reg         irq_reg;
	wire        tick;
	wire        vote;
	wire        vote_tick;
	wire        last_tick;
	wire        nine_bit;
	wire        has_parity;
	wire        frame_done;
	wire        drop_word;
	wire        fifo_full;
	wire        push;
	wire        set_overrun;
	wire        flush;
	wire [2:0]  fill;
	wire [2:0]  fill_after;
	reg         irq_cond;
	wire [10:0] head;
	wire [8:0]  rx_word;

	assign nine_bit   = (width_parity_select == `URBD_WPS_9N);
	assign has_parity = (width_parity_select == `URBD_WPS_8E) |
			    (width_parity_select == `URBD_WPS_8O);

	// =========================================================
	// transmit line override
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_line_reg <= 1'b1;
			tx_irq_reg  <= 1'b0;
		end else begin
			if (!module_enable_bit) begin
				tx_line_reg <= 1'b1;
			end else if (break_send_bit) begin
				tx_line_reg <= 1'b0;
			end else if (tx_shift_busy) begin
				tx_line_reg <= tx_shift_bit;
			end else begin
				tx_line_reg <= 1'b1;
			end
			// loads during a break are not reported
			tx_irq_reg <= tx_word_loaded & ~break_send_bit &
				      module_enable_bit;
		end
	end
	assign serial_tx_line = tx_line_reg;
	assign tx_irq_set     = tx_irq_reg;

	// =========================================================
	// input synchroniser and 16x tick
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			div_reg     <= 16'h0000;
		end else begin
			rx_meta_reg <= serial_rx_line;
			rx_sync_reg <= rx_meta_reg;
			if (!module_enable_bit || div_reg == baud_divisor_reg) begin
				div_reg <= 16'h0000;
			end else begin
				div_reg <= div_reg + 16'h0001;
			end
		end
	end
	// one tick per sixteenth of a bit
	assign tick = module_enable_bit & (div_reg == baud_divisor_reg);

	// two of three samples decide the level
	assign vote = (samp_a_reg & samp_b_reg) | (samp_a_reg & rx_sync_reg) |
		      (samp_b_reg & rx_sync_reg);
	assign vote_tick = tick & (sub_reg == `URBD_SAMPLE_C);
	assign last_tick = tick & (sub_reg == `URBD_OVS_LAST);
	assign frame_done = vote_tick & (state_reg == ST_STOP) & ~stop2_reg;

	// =========================================================
	// bit-level receive state machine
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg   <= ST_IDLE;
			sub_reg     <= 4'h0;
			samp_a_reg  <= 1'b1;
			samp_b_reg  <= 1'b1;
			bits_reg    <= 4'h0;
			shift_reg   <= 9'h000;
			par_acc_reg <= 1'b0;
			parity_error_flag_reg    <= 1'b0;
			framing_error_flag_reg    <= 1'b0;
			stop2_reg   <= 1'b0;
			armed_reg   <= 1'b0;
		end else if (!module_enable_bit) begin
			state_reg <= ST_IDLE;
			sub_reg   <= 4'h0;
			armed_reg <= 1'b0;
		end else if (tick) begin
			sub_reg <= sub_reg + 4'h1;
			if (sub_reg == `URBD_SAMPLE_A) begin
				samp_a_reg <= rx_sync_reg;
			end
			if (sub_reg == `URBD_SAMPLE_B) begin
				samp_b_reg <= rx_sync_reg;
			end
			case (state_reg)
			ST_IDLE: begin
				sub_reg <= 4'h0;
				// after a break, wait for the line to go high first
				if (rx_sync_reg) begin
					armed_reg <= 1'b1;
				end else if (armed_reg && !held_reg) begin
					state_reg   <= ST_START;
					sub_reg     <= 4'h1;
					par_acc_reg <= 1'b0;
					framing_error_flag_reg    <= 1'b0;
					parity_error_flag_reg    <= 1'b0;
					bits_reg    <= 4'h0;
				end
			end
			ST_START: begin
				// a glitch shorter than half a bit is not a start
				if (sub_reg == `URBD_SAMPLE_C && vote) begin
					state_reg <= ST_IDLE;
				end else if (sub_reg == `URBD_OVS_LAST) begin
					state_reg <= ST_DATA;
				end
			end
			ST_DATA: begin
				if (sub_reg == `URBD_SAMPLE_C) begin
					shift_reg   <= {vote, shift_reg[8:1]};
					par_acc_reg <= par_acc_reg ^ vote;
					bits_reg    <= bits_reg + 4'h1;
				end else if (sub_reg == `URBD_OVS_LAST) begin
					if (bits_reg == (nine_bit ? `URBD_BITS_NINE : `URBD_BITS_EIGHT)) begin
						state_reg <= has_parity ? ST_PARITY : ST_STOP;
						stop2_reg <= stop_bits_select;
					end
				end
			end
			ST_PARITY: begin
				if (sub_reg == `URBD_SAMPLE_C) begin
					parity_error_flag_reg <= par_acc_reg ^ vote ^
						    (width_parity_select == `URBD_WPS_8O);
				end else if (sub_reg == `URBD_OVS_LAST) begin
					state_reg <= ST_STOP;
				end
			end
			ST_STOP: begin
				if (sub_reg == `URBD_SAMPLE_C) begin
					framing_error_flag_reg <= framing_error_flag_reg | ~vote;
					if (!stop2_reg) begin
						state_reg <= ST_IDLE;
						armed_reg <= vote;
					end
				end else if (sub_reg == `URBD_OVS_LAST) begin
					stop2_reg <= 1'b0;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	assign rx_word = nine_bit ? shift_reg : {1'b0, shift_reg[8:1]};

	// =========================================================
	// word hand-off, overrun and address filter
	assign drop_word   = nine_bit & address_detect_enable &
			     ~word_reg[8];
	assign push        = held_reg & ~drop_word & ~overrun_reg &
			     ~fifo_full;
	assign set_overrun = held_reg & ~drop_word & ~overrun_reg & fifo_full;
	assign flush       = ~module_enable_bit | (overrun_clear & overrun_reg);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			word_reg      <= 9'h000;
			word_framing_error_flag_reg <= 1'b0;
			word_parity_error_flag_reg <= 1'b0;
			held_reg      <= 1'b0;
			overrun_reg   <= 1'b0;
		end else if (!module_enable_bit) begin
			held_reg    <= 1'b0;
			overrun_reg <= 1'b0;
		end else begin
			if (frame_done) begin
				word_reg      <= rx_word;
				word_framing_error_flag_reg <= framing_error_flag_reg | ~vote;
				word_parity_error_flag_reg <= parity_error_flag_reg & ~nine_bit;
				held_reg      <= 1'b1;
			end else if (push || (held_reg && drop_word)) begin
				held_reg <= 1'b0;
			end
			// the overrun word stays held until the flag is cleared
			overrun_reg <= set_overrun | (overrun_reg & ~overrun_clear);
		end
	end

	urbd_rx_fifo u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.flush     (flush),
		.push      (push),
		.push_data ({word_parity_error_flag_reg, word_framing_error_flag_reg, word_reg}),
		.pop       (rx_read),
		.head_data (head),
		.count     (fill),
		.full      (fifo_full)
	);

	// =========================================================
	// receive interrupt flag
	assign fill_after = rx_read & (fill != 3'h0) ? fill : fill + 3'h1;
	always @* begin
		case (rx_irq_select)
		`URBD_RXSEL_3UP:  irq_cond = (fill_after >= `URBD_FILL_THREE);
		`URBD_RXSEL_FULL: irq_cond = (fill_after == `URBD_FILL_FULL);
		default:          irq_cond = 1'b1;
		endcase
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_reg <= 1'b0;
		end else begin
			// a new qualifying transfer beats a clear in the same cycle
			irq_reg <= (push & irq_cond) | (irq_reg & ~rx_irq_clear);
		end
	end

	assign rx_irq_flag        = irq_reg;
	assign rx_data_register   = head[8:0];
	assign framing_error_flag = head[`URBD_ENTRY_FRAME_ERR] & rx_data_available;
	assign parity_error_flag  = head[`URBD_ENTRY_PARITY_ERR] & rx_data_available;
	assign rx_data_available  = (fill != 3'h0);
	assign overrun_flag       = overrun_reg;
	assign receiver_idle_flag = (state_reg == ST_IDLE) & ~held_reg;

endmodule // urbd_receiver

// *** bench/urbd_receiver_properties.sv ***
// port-level checker for the serial receiver
`timescale 1ns/1ps

module urbd_receiver_properties (
	input wire       clk,
	input wire       nrst,
	input wire       module_enable_bit,
	input wire       break_send_bit,
	input wire       tx_shift_busy,
	input wire [1:0] rx_irq_select,
	input wire       overrun_clear,
	input wire       rx_irq_clear,
	input wire       serial_tx_line,
	input wire       tx_irq_set,
	input wire       framing_error_flag,
	input wire       parity_error_flag,
	input wire       rx_data_available,
	input wire       overrun_flag,
	input wire       receiver_idle_flag,
	input wire       rx_irq_flag
);
	// ==========
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// flush lands first, the held word follows one cycle later
	sequence s_flushed;
		!overrun_flag && !rx_data_available ##1 rx_data_available;
	endsequence
	property p_break_low;
		module_enable_bit && break_send_bit |=> !serial_tx_line;
	endproperty
	property p_tx_idle;
		module_enable_bit && !break_send_bit && !tx_shift_busy |=> serial_tx_line;
	endproperty
	property p_no_tx_irq;
		break_send_bit |=> !tx_irq_set;
	endproperty
	property p_irq_on_push;
		$rose(rx_data_available) && !rx_irq_select[1] |=> rx_irq_flag;
	endproperty
	property p_irq_cause;
		$rose(rx_irq_flag) |-> rx_data_available;
	endproperty
	property p_ovr_busy;
		overrun_flag |-> !receiver_idle_flag;
	endproperty
	property p_ovr_stays;
		overrun_flag && !overrun_clear && module_enable_bit |=> overrun_flag;
	endproperty
	property p_ovr_clear;
		overrun_flag && overrun_clear && module_enable_bit |=> s_flushed;
	endproperty
	property p_irq_sticky;
		rx_irq_flag && !rx_irq_clear && module_enable_bit |=> rx_irq_flag;
	endproperty
	property p_empty_clean;
		!rx_data_available |-> !framing_error_flag && !parity_error_flag;
	endproperty

	a_break_low: assert property (p_break_low) else $error("tx not low in break");
	a_tx_idle: assert property (p_tx_idle) else $error("tx not idle high");
	a_no_tx_irq: assert property (p_no_tx_irq) else $error("tx irq during break");
	a_irq_on_push: assert property (p_irq_on_push) else $error("no irq on push");
	a_irq_cause: assert property (p_irq_cause) else $error("irq without data");
	a_ovr_busy: assert property (p_ovr_busy) else $error("idle with held word");
	a_ovr_stays: assert property (p_ovr_stays) else $error("overrun dropped");
	a_ovr_clear: assert property (p_ovr_clear) else $error("bad overrun clear");
	a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag lost");
	a_empty_clean: assert property (p_empty_clean) else $error("flags when empty");
endmodule // urbd_receiver_properties

bind urbd_receiver urbd_receiver_properties i_props (.clk, .nrst, .module_enable_bit,
	.break_send_bit, .tx_shift_busy, .rx_irq_select, .overrun_clear, .rx_irq_clear,
	.serial_tx_line, .tx_irq_set, .framing_error_flag, .parity_error_flag,
	.rx_data_available, .overrun_flag, .receiver_idle_flag, .rx_irq_flag);

// *** bench/urbd_remote_uart.sv ***
// remote sender on the serial line
`timescale 1ns/1ps

module urbd_remote_uart (
	input wire clk,
	output reg line
);
	// ==========
	// frame sender, sixteen clocks a bit at divisor zero
	initial line = 1'b1;

	task automatic hold(input logic lvl);
		line = lvl;
		repeat (16) @(negedge clk);
	endtask

	// trailing high bit rearms the receiver after a low stop
	task automatic send(input logic [8:0] w, input logic [1:0] ps, input logic bad_par,
		input logic stop_ok);
		int i;
		logic p;
		p = (ps == 2'h2) ^ (^w[7:0]) ^ bad_par;
		@(negedge clk);
		hold(1'b0);
		for (i = 0; i < ((ps == 2'h3) ? 9 : 8); i++) hold(w[i]);
		if (ps == 2'h1 || ps == 2'h2) hold(p);
		hold(stop_ok);
		hold(1'b1);
	endtask
endmodule // urbd_remote_uart

// *** bench/tb_urbd_receiver.sv ***
// self-checking bench for the serial receiver
`timescale 1ns/1ps

module tb_urbd_receiver;
	// ==========
	// signals and instances
	typedef struct packed {
		logic [8:0] word;
		logic [1:0] ps;
		logic       bad_par;
		logic       stop_ok;
		logic [8:0] exp_data;
		logic       exp_framing_error_flag;
		logic       exp_parity_error_flag;
	} urbd_row_t;

	logic clk, nrst, module_enable_bit, stop_bits_select, address_detect_enable;
	logic break_send_bit, tx_shift_busy, tx_shift_bit, tx_word_loaded;
	logic rx_read, overrun_clear, rx_irq_clear;
	logic [1:0] width_parity_select, rx_irq_select;
	logic [15:0] baud_divisor_reg;
	wire serial_rx_line, serial_tx_line, tx_irq_set, framing_error_flag, parity_error_flag;
	wire rx_data_available, overrun_flag, receiver_idle_flag, rx_irq_flag;
	wire [8:0] rx_data_register;
	int bad_count, n_checks, cycles;
	urbd_row_t rows [8] = '{
		'{9'h055, 2'h0, 1'h0, 1'h1, 9'h055, 1'h0, 1'h0},
		'{9'h0a3, 2'h1, 1'h0, 1'h1, 9'h0a3, 1'h0, 1'h0},
		'{9'h0a3, 2'h1, 1'h1, 1'h1, 9'h0a3, 1'h0, 1'h1},
		'{9'h1b6, 2'h2, 1'h0, 1'h1, 9'h0b6, 1'h0, 1'h0},
		'{9'h0b6, 2'h2, 1'h1, 1'h1, 9'h0b6, 1'h0, 1'h1},
		'{9'h1a5, 2'h3, 1'h1, 1'h1, 9'h1a5, 1'h0, 1'h0},
		'{9'h0ff, 2'h0, 1'h0, 1'h0, 9'h0ff, 1'h1, 1'h0},
		'{9'h000, 2'h0, 1'h0, 1'h0, 9'h000, 1'h1, 1'h0}};

	urbd_receiver i_dut (.clk, .nrst, .module_enable_bit, .width_parity_select,
		.stop_bits_select, .baud_divisor_reg, .rx_irq_select, .address_detect_enable,
		.break_send_bit, .tx_shift_busy, .tx_shift_bit, .tx_word_loaded, .serial_rx_line,
		.rx_read, .overrun_clear, .rx_irq_clear, .serial_tx_line, .tx_irq_set,
		.rx_data_register, .framing_error_flag, .parity_error_flag, .rx_data_available,
		.overrun_flag, .receiver_idle_flag, .rx_irq_flag);
	urbd_remote_uart i_remote (.clk, .line(serial_rx_line));

	always #50 clk = ~clk;

	// ==========
	// helpers
	task automatic close_out();
		if (bad_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task automatic pop_clear();
		@(negedge clk);
		rx_read = 1'b1;
		rx_irq_clear = 1'b1;
		@(negedge clk);
		rx_read = 1'b0;
		rx_irq_clear = 1'b0;
	endtask

	// hang guard, frames take about two hundred cycles each
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end

	// ==========
	// sequence
	initial begin
		urbd_row_t r;
		{clk, nrst, stop_bits_select, address_detect_enable, break_send_bit} = '0;
		{tx_shift_busy, tx_shift_bit, tx_word_loaded, rx_read, overrun_clear} = '0;
		{rx_irq_clear, width_parity_select, rx_irq_select, baud_divisor_reg} = '0;
		{bad_count, n_checks, cycles} = '0;
		module_enable_bit = 1'b1;
		repeat (6) @(negedge clk);
		chk(serial_tx_line === 1'b1 && receiver_idle_flag === 1'b1, "reset idle");
		chk(rx_data_available === 1'b0 && rx_irq_flag === 1'b0, "reset flags");
		nrst = 1'b1;
		for (int k = 0; k < 8; k++) begin
			r = rows[k];
			@(negedge clk);
			width_parity_select = r.ps;
			rx_irq_select = k[0] ? 2'h1 : 2'h0;
			i_remote.send(r.word, r.ps, r.bad_par, r.stop_ok);
			chk(rx_data_available === 1'b1 && rx_irq_flag === 1'b1, "no word");
			chk(rx_data_register === r.exp_data, "data");
			chk(framing_error_flag === r.exp_framing_error_flag, "framing");
			chk(parity_error_flag === r.exp_parity_error_flag, "parity");
			pop_clear();
			chk(rx_data_available === 1'b0 && rx_irq_flag === 1'b0, "not emptied");
		end
		@(negedge clk);
		{tx_shift_busy, tx_shift_bit, tx_word_loaded, break_send_bit} = 4'hf;
		@(negedge clk);
		chk(serial_tx_line === 1'b0 && tx_irq_set === 1'b0, "break");
		{tx_shift_busy, tx_word_loaded, break_send_bit} = 3'h0;
		@(negedge clk);
		chk(serial_tx_line === 1'b1, "tx not idle");
		{tx_shift_busy, tx_shift_bit, tx_word_loaded} = 3'h5;
		@(negedge clk);
		chk(serial_tx_line === 1'b0 && tx_irq_set === 1'b1, "tx pass");
		{tx_shift_busy, tx_word_loaded} = 2'h0;
		// full break from an idle transmitter, sixteen clocks a bit time
		break_send_bit = 1'b1;
		repeat (13 * 16) @(negedge clk);
		chk(serial_tx_line === 1'b0 && tx_irq_set === 1'b0, "break held");
		break_send_bit = 1'b0;
		repeat (32) @(negedge clk);
		chk(serial_tx_line === 1'b1, "no stop bit");
		width_parity_select = 2'h0;
		rx_irq_select = 2'h3;
		for (int k = 0; k < 3; k++) i_remote.send(9'h010 + k, 2'h0, 1'h0, 1'h1);
		chk(rx_irq_flag === 1'b0, "irq before full");
		@(negedge clk);
		rx_irq_select = 2'h2;
		i_remote.send(9'h013, 2'h0, 1'h0, 1'h1);
		chk(rx_irq_flag === 1'b1, "no irq at four");
		i_remote.send(9'h014, 2'h0, 1'h0, 1'h1);
		chk(overrun_flag === 1'b1 && rx_data_register === 9'h010, "overrun");
		chk(receiver_idle_flag === 1'b0, "idle with held word");
		overrun_clear = 1'b1;
		@(negedge clk);
		overrun_clear = 1'b0;
		chk(overrun_flag === 1'b0 && rx_data_available === 1'b0, "no flush");
		@(negedge clk);
		chk(rx_data_available === 1'b1 && rx_data_register === 9'h014, "held lost");
		chk(receiver_idle_flag === 1'b1, "not idle");
		pop_clear();
		{rx_irq_select, width_parity_select, address_detect_enable} = 5'h07;
		i_remote.send(9'h0a5, 2'h3, 1'h0, 1'h1);
		chk(rx_data_available === 1'b0 && rx_irq_flag === 1'b0, "data kept");
		i_remote.send(9'h1c3, 2'h3, 1'h0, 1'h1);
		chk(rx_data_available === 1'b1 && rx_data_register === 9'h1c3, "addr lost");
		pop_clear();
		// address matched: software lets data words through, then re-arms
		address_detect_enable = 1'b0;
		i_remote.send(9'h0a5, 2'h3, 1'h0, 1'h1);
		chk(rx_data_register === 9'h0a5 && rx_irq_flag === 1'b1, "data dropped");
		pop_clear();
		address_detect_enable = 1'b1;
		width_parity_select = 2'h0;
		i_remote.send(9'h03c, 2'h0, 1'h0, 1'h1);
		chk(rx_data_available === 1'b1 && rx_data_register === 9'h03c, "byte lost");
		pop_clear();
		// two stop bits: the trailing high bit is the second stop
		stop_bits_select = 1'b1;
		i_remote.send(9'h0c3, 2'h0, 1'h0, 1'h0);
		chk(rx_data_available === 1'b1 && rx_data_register === 9'h0c3, "two stops");
		chk(framing_error_flag === 1'b1, "first stop low");
		close_out();
	end
endmodule // tb_urbd_receiver
